// ---- ats_params.svh ----
/*
  constants for the aided trip scheme logic: timing figures and tick derivation.
  assumes inclusion by bare name from the timer and trip logic modules.
*/
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

// ------------------------------------------------------------
// clock and millisecond tick
// ------------------------------------------------------------
`define ATS_CLK_PERIOD_NS 40
`define ATS_TICK_PERIOD_NS 1000000
`define ATS_TICK_CYCLES (`ATS_TICK_PERIOD_NS / `ATS_CLK_PERIOD_NS)

// ------------------------------------------------------------
// unblocking and alarm timing, in milliseconds
// ------------------------------------------------------------
`define ATS_UNBLOCK_START_MS 16'h000A
`define ATS_UNBLOCK_LEN_MS 16'h0096
`define ATS_ALARM_PICKUP_MS 16'h0096

// ------------------------------------------------------------
// timer reset and saturation values
// ------------------------------------------------------------
`define ATS_MS_COUNT_RST 16'h0000
`define ATS_MS_COUNT_MAX 16'hFFFF

`endif

// ---- ats_pkg.sv ----
/*
  types shared by the aided trip scheme logic and its millisecond timer.
  assumes ats_params.svh is compiled with it.
*/
`default_nettype none

package ats_pkg;

  // scheme mode selection
  typedef enum logic [1:0] {
    ATS_MODE_OFF,
    ATS_MODE_UNDERREACH,
    ATS_MODE_POR
  } ats_mode_e;

  // local distance zone detector pickups
  typedef struct packed {
    logic z1;
    logic z2;
    logic z3;
    logic z4;
  } ats_zone_s;

  // per-phase flags: undervoltage pickups and trip commands
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } ats_phase_s;

  // option enables
  typedef struct packed {
    logic unblock_en;
    logic weak_infeed_echo_en;
    logic weak_infeed_trip_en;
    logic single_pole_en;
    logic extend_on_channel_fail_en;
  } ats_cfg_s;

  // timer state
  typedef struct packed {
    logic [15:0] count;
  } ats_tmr_s;

  // top-level state
  typedef struct packed {
    logic [14:0] tick_cnt;
    logic ms_tick;
    logic signal_send;
    logic aided_trip;
    ats_phase_s wi_trip;
    logic channel_alarm;
    logic extended_first_zone_invoke;
    logic reverse_fault;
  } ats_state_s;

endpackage

`default_nettype wire

// ---- ats_ms_timer.sv ----
/*
  millisecond run timer: counts ticks while its run input is high.
  assumes a one-cycle ms_tick pulse from the owner's clock domain.
*/
`include "ats_params.svh"
`default_nettype none

module ats_ms_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ms_tick,
  input wire logic run,
  output logic [15:0] elapsed_ms
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ats_pkg::ats_tmr_s state_ff; // registered count
  ats_pkg::ats_tmr_s nxt_state; // next count

  // clear on drop of run so every pickup restarts from zero; saturates
  always_comb begin
    nxt_state = state_ff;
    if (!run) begin
      nxt_state.count = `ATS_MS_COUNT_RST;
    end else if (ms_tick && state_ff.count != `ATS_MS_COUNT_MAX) begin
      nxt_state.count = state_ff.count + 16'h0001;
    end
  end

  // register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.count <= `ATS_MS_COUNT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign elapsed_ms = state_ff.count;

endmodule

`default_nettype wire

// ---- ats_trip_logic.sv ----
/*
  aided trip scheme logic for one line end: signal send, permissive trip,
  weak infeed echo and trip, loss-of-guard unblocking and channel alarm.
  assumes all inputs synchronous to clk_sys; basic stepped distance tripping
  lives elsewhere and is never gated here.
// Overview of operation
// - underreach mode: zone 1 keys send
// - zone 2 plus received gives instant trip
// - overreach mode: zone 2 keys send
// - channel failure leaves basic tripping untouched
// - zone 4 flags reverse fault for guard/echo
// - echo and weak trip independently enabled
// - echo: received with no zone keys send
// - weak trip: no zone, undervoltage, received
// - weak trip waits configured delay
// - single pole trips faulted phase else three
// - both asserted permit; neither permits nothing
// - guard loss alone: window 10ms..160ms
// - disagreement alarms after 150ms; anomaly blocks
// - alarm invokes extended zone 1 if enabled
// - shared channel send and receive are ORed
*/
`include "ats_params.svh"
`default_nettype none

module ats_trip_logic #(
  parameter int TICK_CYCLES = `ATS_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ats_pkg::ats_mode_e mode,
  input wire ats_pkg::ats_cfg_s cfg,
  input wire logic [15:0] weak_infeed_trip_delay,
  input wire ats_pkg::ats_zone_s zone,
  input wire ats_pkg::ats_phase_s uv,
  input wire logic channel_receive,
  input wire logic loss_of_guard,
  input wire logic aux_send_req,
  input wire logic aux_channel_receive,
  output logic signal_send,
  output logic aided_trip,
  output ats_pkg::ats_phase_s wi_trip,
  output logic channel_alarm,
  output logic extended_first_zone_invoke,
  output logic reverse_fault
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // true once a timer has run for at least lim milliseconds
  function automatic logic ms_reached(input logic [15:0] elapsed, input logic [15:0] lim);
    ms_reached = (elapsed >= lim);
  endfunction

  // ------------------------------------------------------------
  // state and timers
  // ------------------------------------------------------------
  ats_pkg::ats_state_s state_ff; // all registered state
  ats_pkg::ats_state_s nxt_state; // next state
  logic [15:0] guard_ms; // time since guard loss
  logic [15:0] alarm_ms; // time of receive/guard disagreement
  logic [15:0] wi_ms; // time weak trip condition held
  logic is_underreach; // underreach mode selected
  logic is_por; // overreach mode selected
  logic any_zone; // any distance zone picked up
  logic mismatch; // receive and guard loss disagree
  logic unblock_win; // unblock window open
  logic rx_eff; // effective channel received
  logic wi_cond; // weak trip start condition

  // guard loss timer drives the unblock window
  ats_ms_timer u_guard_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ms_tick(state_ff.ms_tick),
    .run(cfg.unblock_en && loss_of_guard),
    .elapsed_ms(guard_ms)
  );

  // alarm pickup timer
  ats_ms_timer u_alarm_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ms_tick(state_ff.ms_tick),
    .run(mismatch),
    .elapsed_ms(alarm_ms)
  );

  // weak infeed trip delay timer
  ats_ms_timer u_wi_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ms_tick(state_ff.ms_tick),
    .run(wi_cond),
    .elapsed_ms(wi_ms)
  );

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------

  // decode of channel receive, guard loss and shared channel
  always_comb begin
    is_underreach = (mode == ats_pkg::ATS_MODE_UNDERREACH);
    is_por = (mode == ats_pkg::ATS_MODE_POR);
    any_zone = zone.z1 | zone.z2 | zone.z3 | zone.z4;
    // the other scheme's channel has no guard, so only the primary disagrees
    mismatch = cfg.unblock_en && (channel_receive ^ loss_of_guard);
    // window opens after the equipment's frequency shift time
    unblock_win = ms_reached(guard_ms, `ATS_UNBLOCK_START_MS) &&
                  !ms_reached(guard_ms, `ATS_UNBLOCK_START_MS + `ATS_UNBLOCK_LEN_MS);
    if (cfg.unblock_en) begin
      // both: permit; neither: nothing; received without loss: blocked
      rx_eff = (channel_receive && loss_of_guard) || (!channel_receive && loss_of_guard && unblock_win);
    end else begin
      // plain receive input relied on as driven by the channel gear
      rx_eff = channel_receive;
    end
    rx_eff = rx_eff | aux_channel_receive;
    // weak trip only alongside overreach, echo-style conditions
    wi_cond = is_por && cfg.weak_infeed_trip_en && !any_zone && (|uv) && rx_eff;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // tick divider, one pulse each millisecond
    if (state_ff.tick_cnt == 15'(TICK_CYCLES - 1)) begin
      nxt_state.tick_cnt = 15'h0000;
      nxt_state.ms_tick = 1'b1;
    end else begin
      nxt_state.tick_cnt = state_ff.tick_cnt + 15'h0001;
      nxt_state.ms_tick = 1'b0;
    end

    // reverse fault indication feeds guard and echo
    nxt_state.reverse_fault = is_por && zone.z4;

    // send keying
    nxt_state.signal_send = aux_send_req;
    if (is_underreach && zone.z1) begin
      nxt_state.signal_send = 1'b1;
    end
    // reverse fault inhibits overreach send as a simple guard
    if (is_por && zone.z2 && !zone.z4) begin
      nxt_state.signal_send = 1'b1;
    end
    if (is_por && cfg.weak_infeed_echo_en && !any_zone && rx_eff) begin
      nxt_state.signal_send = 1'b1;
    end

    // aided trip, no intentional delay; basic zone tripping is separate
    nxt_state.aided_trip = (is_underreach || (is_por && !zone.z4)) && zone.z2 && rx_eff;

    // weak infeed trip after the set delay
    if (wi_cond && ms_reached(wi_ms, weak_infeed_trip_delay)) begin
      if (cfg.single_pole_en) begin
        nxt_state.wi_trip = uv;
      end else begin
        nxt_state.wi_trip = 3'b111;
      end
    end else begin
      nxt_state.wi_trip = 3'b000;
    end

    // channel alarm after pickup delay, drops as soon as inputs agree
    nxt_state.channel_alarm = mismatch && ms_reached(alarm_ms, `ATS_ALARM_PICKUP_MS);
    nxt_state.extended_first_zone_invoke = state_ff.channel_alarm && cfg.extend_on_channel_fail_en;
  end

  // ------------------------------------------------------------
  // register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flip-flops
  assign signal_send = state_ff.signal_send;
  assign aided_trip = state_ff.aided_trip;
  assign wi_trip = state_ff.wi_trip;
  assign channel_alarm = state_ff.channel_alarm;
  assign extended_first_zone_invoke = state_ff.extended_first_zone_invoke;
  assign reverse_fault = state_ff.reverse_fault;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_underreach_send: assert property (is_underreach && zone.z1 |=> signal_send)
    else $error("underreach send missing");
  a_por_send_key: assert property (is_por && zone.z2 && !zone.z4 |=> signal_send)
    else $error("overreach send missing");
  a_aided_trip_fast: assert property (is_underreach && zone.z2 && rx_eff |=> aided_trip)
    else $error("aided trip missing");
  a_reverse_flag: assert property (is_por && zone.z4 |=> reverse_fault && !aided_trip)
    else $error("reverse fault not flagged");
  a_echo_send: assert property (is_por && cfg.weak_infeed_echo_en && !any_zone && rx_eff |=> signal_send)
    else $error("echo send missing");
  a_unblock_idle: assert property (cfg.unblock_en && !channel_receive && !loss_of_guard && !aux_channel_receive
                                   |=> !aided_trip)
    else $error("trip with healthy channel");
  a_anomaly_block: assert property (cfg.unblock_en && channel_receive && !loss_of_guard && !aux_channel_receive
                                    |=> !aided_trip)
    else $error("trip on signalling anomaly");
  a_window_open: assert property (cfg.unblock_en && loss_of_guard && !channel_receive &&
                                  guard_ms >= 16'h000A && guard_ms < 16'h00A0 |-> rx_eff)
    else $error("unblock window closed");
  a_window_shut: assert property (cfg.unblock_en && loss_of_guard && !channel_receive && !aux_channel_receive &&
                                  guard_ms < 16'h000A |-> !rx_eff)
    else $error("unblock window early");
  a_alarm_delay: assert property ($rose(channel_alarm) |-> $past(alarm_ms) >= 16'h0096 && $past(mismatch))
    else $error("alarm before pickup delay");
  a_extension_follow: assert property (channel_alarm && cfg.extend_on_channel_fail_en
                                       |=> extended_first_zone_invoke)
    else $error("zone 1 extension not invoked");
  // extension must stay off whenever the option is disabled
  a_extension_off: assert property (!cfg.extend_on_channel_fail_en |=> !extended_first_zone_invoke)
    else $error("zone 1 extension while disabled");
  // alarm must fall as soon as receive and guard loss agree again
  a_alarm_drop: assert property (!mismatch |=> !channel_alarm)
    else $error("alarm held after agreement");
  // both tones at once is a genuine line fault: trip must go through
  a_both_permit: assert property (cfg.unblock_en && channel_receive && loss_of_guard && is_underreach && zone.z2
                                  |=> aided_trip)
    else $error("trip refused on line fault");
  // no scheme selected: the aided path stays quiet
  a_off_no_trip: assert property (mode == ats_pkg::ATS_MODE_OFF |=> !aided_trip)
    else $error("aided trip with scheme off");
  // the other scheme's send request always reaches the channel
  a_aux_send: assert property (aux_send_req |=> signal_send)
    else $error("shared send request lost");
  // the other scheme's receive also permits the trip
  a_aux_receive: assert property (is_underreach && zone.z2 && aux_channel_receive |=> aided_trip)
    else $error("shared receive ignored");
  // single pole: only the phases whose undervoltage picked up
  a_wi_single_pole: assert property (wi_cond && cfg.single_pole_en && wi_ms >= weak_infeed_trip_delay
                                     |=> wi_trip == $past(uv))
    else $error("single pole weak trip wrong phase");
  // weak trip never outlives its start condition
  a_wi_release: assert property (!wi_cond |=> wi_trip == 3'b000)
    else $error("weak trip without condition");
  // the tick pulse marks the wrap of the divider
  a_tick_wrap: assert property (state_ff.ms_tick |-> state_ff.tick_cnt == 15'h0000)
    else $error("tick pulse off divider wrap");
  a_wi_delay: assert property (|wi_trip |-> $past(wi_cond) && $past(wi_ms) >= $past(weak_infeed_trip_delay))
    else $error("weak trip before delay");
  a_wi_three_pole: assert property (wi_cond && !cfg.single_pole_en && wi_ms >= weak_infeed_trip_delay
                                    |=> wi_trip == 3'b111)
    else $error("three pole weak trip missing");

  // main scenarios that the bench is expected to reach
  c_underreach_trip: cover property (is_underreach && aided_trip);
  c_unblock_trip: cover property (cfg.unblock_en && !channel_receive && aided_trip);
  c_alarm_extension: cover property (channel_alarm && extended_first_zone_invoke);
  c_echo_send: cover property (is_por && cfg.weak_infeed_echo_en && !any_zone && rx_eff ##1 signal_send);
  c_wi_single: cover property (cfg.single_pole_en && wi_trip == 3'b100);

endmodule

`default_nettype wire

// ---- ats_remote_relay.sv ----
/*
  remote line-end relay model on the fsk signalling channel.
  assumes the bench drives its commands just after a rising clock edge.
*/
`default_nettype none

module ats_remote_relay (
  input wire logic key_trip,
  input wire logic fade,
  input wire logic anomaly,
  output logic channel_receive,
  output logic loss_of_guard
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // channel outputs: guard tone or trip tone
  // ------------------------------------------------------------
  // trip tone arrives unless the line fault swallows it
  assign channel_receive = (key_trip & ~fade) | anomaly;
  // guard drops when the carrier shifts or is attenuated
  assign loss_of_guard = key_trip | fade;
endmodule

`default_nettype wire

// ---- test_aided_trip_scheme_logic.sv ----
/*
  self-checking bench for the aided trip scheme logic.
  assumes the design files and ats_remote_relay are compiled first.
*/
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module test_aided_trip_scheme_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int TC = 4; // short ms keeps 160 ms windows cheap
  logic clk_sys, rst_n;
  ats_pkg::ats_mode_e mode;
  ats_pkg::ats_cfg_s cfg;
  logic [15:0] weak_infeed_trip_delay;
  ats_pkg::ats_zone_s zone;
  ats_pkg::ats_phase_s uv, wi_trip;
  logic channel_receive, loss_of_guard, aux_send_req, aux_channel_receive;
  logic key_trip, fade, anomaly; // partner commands
  logic signal_send, aided_trip, channel_alarm, extended_first_zone_invoke, reverse_fault;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h0000_0006;
  int t_on, t_off, t_alm, t_ext, i, cnt;

  ats_trip_logic #(.TICK_CYCLES(TC)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode), .cfg(cfg),
    .weak_infeed_trip_delay(weak_infeed_trip_delay), .zone(zone), .uv(uv), .channel_receive(channel_receive),
    .loss_of_guard(loss_of_guard), .aux_send_req(aux_send_req), .aux_channel_receive(aux_channel_receive),
    .signal_send(signal_send), .aided_trip(aided_trip), .wi_trip(wi_trip), .channel_alarm(channel_alarm),
    .extended_first_zone_invoke(extended_first_zone_invoke), .reverse_fault(reverse_fault));
  ats_remote_relay far_end (.key_trip(key_trip), .fade(fade), .anomaly(anomaly),
    .channel_receive(channel_receive), .loss_of_guard(loss_of_guard));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  // xorshift, repeatable from the fixed seed
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  // expected send with unblocking off; no zone includes the reverse zone
  function automatic logic exp_send(input logic rx);
    logic por;
    por = (mode == ats_pkg::ATS_MODE_POR);
    exp_send = aux_send_req | (mode == ats_pkg::ATS_MODE_UNDERREACH && zone.z1) | (por && zone.z2 && !zone.z4)
      | (por && cfg.weak_infeed_echo_en && zone == 4'h0 && rx);
  endfunction
  // reverse zone inhibits the permissive trip in overreach mode
  function automatic logic exp_trip(input logic rx);
    exp_trip = mode != ats_pkg::ATS_MODE_OFF && zone.z2 && rx && !(mode == ats_pkg::ATS_MODE_POR && zone.z4);
  endfunction
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hold one channel condition for 170 ms and log output moments
  task automatic run_chan(input logic k, input logic f, input logic a);
    int j;
    t_on = -1;
    t_off = -1;
    t_alm = -1;
    t_ext = -1;
    @(posedge clk_sys);
    key_trip <= k;
    fade <= f;
    anomaly <= a;
    for (j = 1; j <= 170 * TC; j++) begin
      @(posedge clk_sys);
      #1;
      if (aided_trip === 1'h1 && t_on < 0) t_on = j;
      if (aided_trip !== 1'h1 && t_on >= 0 && t_off < 0) t_off = j;
      if (channel_alarm === 1'h1 && t_alm < 0) t_alm = j;
      if (extended_first_zone_invoke === 1'h1 && t_ext < 0) t_ext = j;
    end
    @(posedge clk_sys);
    key_trip <= 1'h0;
    fade <= 1'h0;
    anomaly <= 1'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("alarm release", 1'h0, channel_alarm)
    `CHK("extension release", 1'h0, extended_first_zone_invoke)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    mode = ats_pkg::ATS_MODE_OFF;
    cfg = '0;
    weak_infeed_trip_delay = 16'h0003;
    zone = '0;
    uv = '0;
    {aux_send_req, aux_channel_receive, key_trip, fade, anomaly} = 5'h00;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("reset outputs", 8'h00, {signal_send, aided_trip, wi_trip, channel_alarm, extended_first_zone_invoke, reverse_fault})
    @(posedge clk_sys);
    rst_n <= 1'h1;
    // random levels, unblocking and weak trip off, zones often clear
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      seed = xs(seed);
      mode <= ats_pkg::ats_mode_e'(seed[1:0] % 2'h3);
      zone <= seed[5:2] & {4{seed[20]}};
      cfg.weak_infeed_echo_en <= seed[8];
      cfg.single_pole_en <= seed[9];
      uv <= seed[12:10];
      {aux_send_req, aux_channel_receive, key_trip, anomaly} <= seed[16:13];
      @(posedge clk_sys);
      #1;
      `CHK("send", exp_send(channel_receive | aux_channel_receive), signal_send)
      `CHK("aided trip", exp_trip(channel_receive | aux_channel_receive), aided_trip)
      `CHK("reverse", mode == ats_pkg::ATS_MODE_POR && zone.z4, reverse_fault)
      `CHK("weak trip idle", 3'h0, wi_trip)
    end
    $display("test random levels done");
    // weak infeed trip, three pole then single pole
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      {aux_send_req, aux_channel_receive, anomaly} <= 3'h0;
      mode <= ats_pkg::ATS_MODE_POR;
      zone <= '0;
      cfg <= '0;
      cfg.weak_infeed_trip_en <= 1'h1;
      cfg.single_pole_en <= i[0];
      uv <= 3'h4;
      key_trip <= 1'h1;
      cnt = 0;
      do begin
        @(posedge clk_sys);
        #1;
        cnt++;
      end while (wi_trip === 3'h0 && cnt < 3 * TC + 4);
      if (cnt >= 3 * TC + 4) begin
        errors++;
        report_and_stop();
      end
      `CHK("weak trip delay", 1'h1, cnt >= 2 * TC + 2 && cnt <= 3 * TC + 2)
      `CHK("weak trip phases", (i == 1) ? 3'h4 : 3'h7, wi_trip)
      @(posedge clk_sys);
      key_trip <= 1'h0;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("weak trip drop", 3'h0, wi_trip)
    end
    $display("test weak infeed done");
    // loss-of-guard unblocking table
    @(posedge clk_sys);
    cfg <= '0;
    cfg.unblock_en <= 1'h1;
    cfg.extend_on_channel_fail_en <= 1'h1;
    zone <= 4'h4;
    uv <= '0;
    run_chan(1'h0, 1'h1, 1'h0);
    `CHK("window start", 1'h1, t_on >= 9 * TC && t_on <= 11 * TC + 2)
    `CHK("window length", 1'h1, t_off - t_on >= 150 * TC - 1 && t_off - t_on <= 150 * TC + 1)
    `CHK("unblock alarm", 140 * TC, t_alm - t_on)
    `CHK("extension follows", t_alm + 1, t_ext)
    run_chan(1'h1, 1'h0, 1'h0);
    `CHK("both trip", 1, t_on)
    `CHK("both no alarm", -1, t_alm)
    run_chan(1'h0, 1'h0, 1'h1);
    `CHK("anomaly no trip", -1, t_on)
    `CHK("anomaly alarm", 1'h1, t_alm >= 149 * TC + 1 && t_alm <= 150 * TC + 2)
    run_chan(1'h0, 1'h0, 1'h0);
    `CHK("healthy no trip", -1, t_on)
    `CHK("healthy no alarm", -1, t_alm)
    @(posedge clk_sys);
    cfg.extend_on_channel_fail_en <= 1'h0;
    run_chan(1'h0, 1'h0, 1'h1);
    `CHK("extension disabled", -1, t_ext)
    $display("test unblocking done");
    report_and_stop();
  end
endmodule

`undef CHK
`default_nettype wire
